// ---- src/charger_ctrl.sv ----
`timescale 1ns/10ps
module charger_ctrl #(
	parameter logic [6:0] DEV_ADDR = 7'h3A,
	parameter int INT_CYC = chg_pkg::INT_PULSE_CYC,
	parameter int PWRUP_CYC = chg_pkg::POWERUP_CYC,
	parameter int WDT_CYC = chg_pkg::WDT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// i2c pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// alert pin, open drain
	output logic host_alert_pulse_n_o,
	output logic host_alert_pulse_n_oe,
	// analog detector results
	input wire chg_pkg::sense_t sense_i,
	// power stage
	output chg_pkg::gates_t gates,
	output logic external_protection_fet_on,
	output logic input_pulldown_on,
	output logic internal_regulator_en,
	output logic sense_en,
	output logic measure_en,
	// adapter signalling
	output chg_pkg::dl_level_t dp_level,
	output chg_pkg::dl_level_t dm_level,
	output logic reduce_current_req
);
	if (INT_CYC < 1 || PWRUP_CYC < 1 || WDT_CYC < 2) begin : g_chk_cnt
		$error("counts must be positive");
	end
	if (chg_pkg::DEAD_CYC >= 4) begin : g_chk_dead
		$error("dead time exceeds the shortest half period");
	end

	chg_pkg::top_st_t r, n;
	chg_pkg::reg_wr_t wr;
	logic [7:0] rd_addr, rd_data;
	logic txn_done;

	i2c_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_i2c (
		.clk(clk),
		.srst(srst),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.wr(wr),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.txn_done(txn_done)
	);

	function automatic logic mode_legal(input logic [2:0] m);
		mode_legal = (m == chg_pkg::MODE_OFF) || (m == chg_pkg::MODE_BYPASS)
			|| (m == chg_pkg::MODE_DIVIDER);
	endfunction

	logic [2:0] mode, new_mode;
	logic pdn, cond_ok, lowq, alert_evt, dead, p1, p2;
	logic [9:0] half_len;

	always_comb begin
		unique case (rd_addr)
			chg_pkg::REG_CTRL: rd_data = r.ctrl;
			chg_pkg::REG_SWFREQ: rd_data = r.swfreq;
			chg_pkg::REG_STATUS: rd_data = {1'b0, r.reduce_req,
				~r.regulator_en, r.sense.vbat_above_min,
				r.sense.input_insert_detect,
				r.ctrl[chg_pkg::CTRL_MODE_LSB +: 3]};
			chg_pkg::REG_PRESET: rd_data = r.preset;
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		n = r;
		alert_evt = 1'b0;
		// three-stage sampling; a bit moves when stages two and three agree
		n.s1 = sense_i;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.sense = chg_pkg::sense_t'((r.s2 & r.s3) | (r.sense & (r.s2 | r.s3)));

		mode = r.ctrl[chg_pkg::CTRL_MODE_LSB +: 3];
		pdn = r.ctrl[chg_pkg::CTRL_PDN_BIT];
		cond_ok = r.sense.input_insert_detect & r.sense.vbat_above_min
			& ~pdn;

		// register writes
		new_mode = wr.data[chg_pkg::CTRL_MODE_LSB +: 3];
		if (wr.wr) begin
			unique case (wr.addr)
				chg_pkg::REG_CTRL: begin
					n.ctrl[chg_pkg::CTRL_CONV_BIT] =
						wr.data[chg_pkg::CTRL_CONV_BIT];
					n.ctrl[chg_pkg::CTRL_PDN_BIT] =
						wr.data[chg_pkg::CTRL_PDN_BIT];
					// once running, only a disable is taken
					if (mode_legal(new_mode) && (mode == chg_pkg::MODE_OFF
						|| new_mode == chg_pkg::MODE_OFF)
						&& (new_mode == chg_pkg::MODE_OFF || cond_ok)) begin
						n.ctrl[chg_pkg::CTRL_MODE_LSB +: 3] = new_mode;
					end
				end
				chg_pkg::REG_SWFREQ: n.swfreq = wr.data;
				chg_pkg::REG_PRESET: n.preset = wr.data & 8'h77;
				default: begin
				end
			endcase
		end

		// losing input or battery stops charging at once
		if (mode != chg_pkg::MODE_OFF && !cond_ok) begin
			n.ctrl[chg_pkg::CTRL_MODE_LSB +: 3] = chg_pkg::MODE_OFF;
			alert_evt = 1'b1;
		end

		// power-up delay, then watchdog
		if (!r.init_done) begin
			n.init_cnt = r.init_cnt + 32'h1;
			if (r.init_cnt == 32'(PWRUP_CYC - 1)) begin
				n.init_done = 1'b1;
				alert_evt = 1'b1;
			end
		end else if (txn_done) begin
			n.wdt_cnt = 32'h0;
		end else if (r.wdt_cnt == 32'(WDT_CYC - 1)) begin
			n.wdt_cnt = 32'h0;
			n.ctrl[chg_pkg::CTRL_MODE_LSB +: 3] = chg_pkg::MODE_OFF;
			n.ctrl[chg_pkg::CTRL_CONV_BIT] = 1'b0;
			alert_evt = 1'b1;
		end else begin
			n.wdt_cnt = r.wdt_cnt + 32'h1;
		end

		// alert pulse; a new event during a pulse restarts it
		if (alert_evt) begin
			n.int_cnt = 32'(INT_CYC);
		end else if (r.int_cnt != 32'h0) begin
			n.int_cnt = r.int_cnt - 32'h1;
		end
		n.alert_oe = (n.int_cnt != 32'h0);
		n.alert_o = 1'b0;

		// switching timebase, used in divider mode only
		half_len = {r.swfreq, 2'b00} + 10'h004;
		mode = n.ctrl[chg_pkg::CTRL_MODE_LSB +: 3];
		if (mode != chg_pkg::MODE_DIVIDER) begin
			n.sw_cnt = 10'h000;
			n.half = 1'b0;
		end else if (r.sw_cnt >= half_len - 10'h001) begin
			n.sw_cnt = 10'h000;
			n.half = ~r.half;
		end else begin
			n.sw_cnt = r.sw_cnt + 10'h001;
		end
		dead = n.sw_cnt < 10'(chg_pkg::DEAD_CYC);
		p1 = ~n.half & ~dead;
		p2 = n.half & ~dead;
		unique case (mode)
			chg_pkg::MODE_DIVIDER: begin
				n.gates.ph1 = '{q1: p1, q2: p2, q3: p1, q4: p2};
				n.gates.ph2 = '{q1: p2, q2: p1, q3: p2, q4: p1};
			end
			chg_pkg::MODE_BYPASS: begin
				n.gates.ph1 = '{q1: 1'b1, q2: 1'b1, q3: 1'b0, q4: 1'b0};
				n.gates.ph2 = '{q1: 1'b1, q2: 1'b1, q3: 1'b0, q4: 1'b0};
			end
			default: n.gates = '0;
		endcase

		// quiescent management; detectors are gated off with the regulator when lowq
		lowq = ~n.sense.adapter_present_detect | n.ctrl[chg_pkg::CTRL_PDN_BIT];
		n.regulator_en = ~lowq;
		n.sense_en = ~lowq;
		n.measure_en = ~lowq & n.ctrl[chg_pkg::CTRL_CONV_BIT];
		n.fet_on = n.sense.adapter_present_detect
			& ~n.ctrl[chg_pkg::CTRL_PDN_BIT];
		n.pdn_on = n.ctrl[chg_pkg::CTRL_PDN_BIT];
		n.reduce_req = (mode != chg_pkg::MODE_OFF)
			& n.sense.vbat_at_reg;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '{ctrl: chg_pkg::CTRL_RST, swfreq: chg_pkg::SWFREQ_RST,
				preset: chg_pkg::PRESET_RST, default: '0};
		end else begin
			r <= n;
		end
	end

	assign host_alert_pulse_n_o = r.alert_o;
	assign host_alert_pulse_n_oe = r.alert_oe;
	assign gates = r.gates;
	assign external_protection_fet_on = r.fet_on;
	assign input_pulldown_on = r.pdn_on;
	assign internal_regulator_en = r.regulator_en;
	assign sense_en = r.sense_en;
	assign measure_en = r.measure_en;
	// each line follows its own field
	assign dp_level = chg_pkg::dl_level_t'(r.preset[chg_pkg::PRESET_DP_LSB +: 3]);
	assign dm_level = chg_pkg::dl_level_t'(r.preset[chg_pkg::PRESET_DM_LSB +: 3]);
	assign reduce_current_req = r.reduce_req;
endmodule

// ---- inc/chg_pkg.sv ----
package chg_pkg;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int DEAD_TIME_PS = 15000;
	localparam int DEAD_CYC = (DEAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INT_PULSE_NS = 256000;
	localparam int INT_PULSE_CYC = INT_PULSE_NS * 1000 / CLK_PERIOD_PS;
	localparam int POWERUP_US = 8000;
	localparam int POWERUP_CYC = POWERUP_US * (1000000 / CLK_PERIOD_PS);
	localparam int WDT_MS = 500;
	localparam int WDT_CYC = WDT_MS * (1000000000 / CLK_PERIOD_PS);

	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SWFREQ = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_PRESET = 8'h36;

	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CONV_BIT = 3;
	localparam int CTRL_PDN_BIT = 4;
	localparam int PRESET_DP_LSB = 0;
	localparam int PRESET_DM_LSB = 4;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] SWFREQ_RST = 8'h18;
	localparam logic [7:0] PRESET_RST = 8'h66;

	// charge_mode_field codes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_BYPASS = 3'h1;
	localparam logic [2:0] MODE_DIVIDER = 3'h2;

	typedef enum logic [2:0] {
		DL_0V0 = 3'h0,
		DL_0V6 = 3'h1,
		DL_1V2 = 3'h2,
		DL_2V0 = 3'h3,
		DL_2V7 = 3'h4,
		DL_3V3 = 3'h5,
		DL_HIZ = 3'h6
	} dl_level_t;

	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic q4;
	} phase_gate_t;

	typedef struct packed {
		phase_gate_t ph1;
		phase_gate_t ph2;
	} gates_t;

	typedef struct packed {
		logic adapter_present_detect;
		logic input_insert_detect;
		logic battery_insert_detect;
		logic vbat_above_min;
		logic vbat_at_reg;
	} sense_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;

	typedef enum logic [5:0] {
		I_IDLE = 6'h01,
		I_ADDR = 6'h02,
		I_ACK = 6'h04,
		I_WR = 6'h08,
		I_RD = 6'h10,
		I_RACK = 6'h20
	} i2c_state_t;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl;
		logic sda;
		i2c_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic first;
		logic sel;
		logic oe;
		logic sda_o;
		reg_wr_t wr;
		logic done;
	} i2c_st_t;

	typedef struct packed {
		sense_t s1;
		sense_t s2;
		sense_t s3;
		sense_t sense;
		logic [7:0] ctrl;
		logic [7:0] swfreq;
		logic [7:0] preset;
		logic [31:0] init_cnt;
		logic init_done;
		logic [31:0] wdt_cnt;
		logic [31:0] int_cnt;
		logic [9:0] sw_cnt;
		logic half;
		gates_t gates;
		logic alert_oe;
		logic alert_o;
		logic fet_on;
		logic pdn_on;
		logic regulator_en;
		logic sense_en;
		logic measure_en;
		logic reduce_req;
	} top_st_t;
endpackage

// ---- src/i2c_target.sv ----
`timescale 1ns/10ps
module i2c_target #(
	parameter logic [6:0] DEV_ADDR = 7'h3A
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// i2c pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// register side
	output chg_pkg::reg_wr_t wr,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic txn_done
);
	chg_pkg::i2c_st_t r, n;
	logic scl_rise, scl_fall, start_c, stop_c;

	always_comb begin
		n = r;
		n.wr.wr = 1'b0;
		n.done = 1'b0;
		n.sda_o = 1'b0;
		n.scl_s = {r.scl_s[1:0], scl_i};
		n.sda_s = {r.sda_s[1:0], sda_i};
		// accept a level only once stages two and three agree
		if (r.scl_s[1] == r.scl_s[2]) begin
			n.scl = r.scl_s[2];
		end
		if (r.sda_s[1] == r.sda_s[2]) begin
			n.sda = r.sda_s[2];
		end
		scl_rise = ~r.scl & n.scl;
		scl_fall = r.scl & ~n.scl;
		start_c = r.scl & n.scl & r.sda & ~n.sda;
		stop_c = r.scl & n.scl & ~r.sda & n.sda;
		if (start_c) begin
			n.st = chg_pkg::I_ADDR;
			n.cnt = 4'h0;
			n.oe = 1'b0;
		end else if (stop_c) begin
			n.done = r.sel;
			n.sel = 1'b0;
			n.st = chg_pkg::I_IDLE;
			n.oe = 1'b0;
		end else if (scl_rise) begin
			if (r.st == chg_pkg::I_ADDR || r.st == chg_pkg::I_WR) begin
				n.sh = {r.sh[6:0], n.sda};
				n.cnt = r.cnt + 4'h1;
			end else if (r.st == chg_pkg::I_RD) begin
				n.cnt = r.cnt + 4'h1;
			end else if (r.st == chg_pkg::I_RACK) begin
				// a nack ends the read; wait for stop
				if (n.sda) begin
					n.st = chg_pkg::I_IDLE;
				end else begin
					n.ptr = r.ptr + 8'h01;
				end
			end
		end else if (scl_fall) begin
			unique case (r.st)
				chg_pkg::I_IDLE: begin
				end
				chg_pkg::I_ADDR: begin
					if (r.cnt == 4'h8) begin
						if (r.sh[7:1] == DEV_ADDR) begin
							n.sel = 1'b1;
							n.rw = r.sh[0];
							n.first = ~r.sh[0];
							n.oe = 1'b1;
							n.st = chg_pkg::I_ACK;
						end else begin
							n.st = chg_pkg::I_IDLE;
						end
					end
				end
				chg_pkg::I_WR: begin
					if (r.cnt == 4'h8) begin
						if (r.first) begin
							n.ptr = r.sh;
							n.first = 1'b0;
						end else begin
							n.wr.wr = 1'b1;
							n.wr.addr = r.ptr;
							n.wr.data = r.sh;
							n.ptr = r.ptr + 8'h01;
						end
						n.oe = 1'b1;
						n.st = chg_pkg::I_ACK;
					end
				end
				chg_pkg::I_ACK: begin
					n.cnt = 4'h0;
					if (r.rw) begin
						n.sh = rd_data;
						n.oe = ~rd_data[7];
						n.st = chg_pkg::I_RD;
					end else begin
						n.oe = 1'b0;
						n.st = chg_pkg::I_WR;
					end
				end
				chg_pkg::I_RD: begin
					if (r.cnt == 4'h8) begin
						n.oe = 1'b0;
						n.st = chg_pkg::I_RACK;
					end else begin
						n.sh = {r.sh[6:0], 1'b0};
						n.oe = ~r.sh[6];
					end
				end
				chg_pkg::I_RACK: begin
					n.cnt = 4'h0;
					n.sh = rd_data;
					n.oe = ~rd_data[7];
					n.st = chg_pkg::I_RD;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '{scl_s: 3'h7, sda_s: 3'h7, scl: 1'b1, sda: 1'b1,
				st: chg_pkg::I_IDLE, default: '0};
		end else begin
			r <= n;
		end
	end

	assign sda_o = r.sda_o;
	assign sda_oe = r.oe;
	assign wr = r.wr;
	assign rd_addr = r.ptr;
	assign txn_done = r.done;
endmodule

// ---- tb/charger_ctrl_asserts.sv ----
`timescale 1ns/10ps
module charger_ctrl_asserts #(
	parameter int INT_CYC = 20,
	parameter int PWRUP_CYC = 50
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// watched outputs and sense inputs
	input wire logic host_alert_pulse_n_oe,
	input wire chg_pkg::sense_t sense_i,
	input wire chg_pkg::gates_t gates,
	input wire logic external_protection_fet_on,
	input wire logic input_pulldown_on,
	input wire logic internal_regulator_en,
	input wire chg_pkg::dl_level_t dp_level,
	input wire chg_pkg::dl_level_t dm_level
);
	logic [31:0] al_r;
	logic [31:0] up_r;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// counters instead of long repetitions
	always_ff @(posedge clk) begin
		if (srst) begin
			al_r <= '0;
			up_r <= '0;
		end else begin
			al_r <= host_alert_pulse_n_oe ? al_r + 32'h1 : '0;
			if (up_r < 32'(PWRUP_CYC + 8)) begin
				up_r <= up_r + 32'h1;
			end
		end
	end
	AST_PAIR_EXCL: assert property (
		!(gates.ph1.q1 && gates.ph1.q4) && !(gates.ph1.q2 && gates.ph1.q3))
		else $error("switch pairs overlap");
	AST_PHASE_OFFSET: assert property (
		gates.ph1.q3 |-> gates.ph2 == 4'h5)
		else $error("second phase not opposite");
	AST_DEAD_TIME: assert property (
		$fell(gates.ph1.q3) |-> gates == 8'h00 [*3])
		else $error("dead time too short");
	AST_BYPASS: assert property (
		gates.ph1.q1 && gates.ph1.q2 |-> gates == 8'hCC)
		else $error("bypass pattern wrong");
	AST_ALERT_LEN: assert property (
		$fell(host_alert_pulse_n_oe) |-> al_r >= 32'(INT_CYC))
		else $error("alert pulse too short");
	AST_PWRUP_QUIET: assert property (
		up_r < 32'(PWRUP_CYC - 2) |-> !host_alert_pulse_n_oe)
		else $error("alert before power-up delay");
	AST_PWRUP_ALERT: assert property (
		up_r == 32'(PWRUP_CYC + 4) |-> host_alert_pulse_n_oe)
		else $error("no power-up alert");
	AST_PDN_QUIET: assert property (
		input_pulldown_on |-> !external_protection_fet_on
		&& !internal_regulator_en)
		else $error("pull-down with fet or regulator on");
	AST_VBAT_LOW: assert property (
		(!sense_i.vbat_above_min) [*8] |-> gates == 8'h00)
		else $error("switching with low battery");
	AST_LEVEL_CODE: assert property (
		dp_level != 3'h7 && dm_level != 3'h7)
		else $error("bad data line level");
endmodule

bind charger_ctrl charger_ctrl_asserts #(
	.INT_CYC(INT_CYC),
	.PWRUP_CYC(PWRUP_CYC)
) u_charger_ctrl_asserts (
	.clk(clk),
	.srst(srst),
	.host_alert_pulse_n_oe(host_alert_pulse_n_oe),
	.sense_i(sense_i),
	.gates(gates),
	.external_protection_fet_on(external_protection_fet_on),
	.input_pulldown_on(input_pulldown_on),
	.internal_regulator_en(internal_regulator_en),
	.dp_level(dp_level),
	.dm_level(dm_level)
);

// ---- tb/i2c_host.sv ----
`timescale 1ns/10ps
module i2c_host #(
	parameter logic [6:0] ADDR = 7'h3A
) (
	// bus pins
	output logic scl,
	output logic sda_o,
	input wire logic sda_i
);
	logic ack_ok;
	// scl stands high between frames
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
		ack_ok = 1'b1;
	end
	// data moves mid-low so the device sees scl fall first
	task automatic bit_io(input logic b, output logic q);
		#16 sda_o = b;
		#16 scl = 1'b1;
		#16 q = sda_i;
		#16 scl = 1'b0;
	endtask
	task automatic start();
		#16 sda_o = 1'b1;
		#16 scl = 1'b1;
		#16 sda_o = 1'b0;
		#16 scl = 1'b0;
	endtask
	task automatic stop();
		#16 sda_o = 1'b0;
		#16 scl = 1'b1;
		#16 sda_o = 1'b1;
		#32;
	endtask
	// ninth bit always released: ack expected or read nack
	task automatic byte_io(input logic [7:0] d, input logic e,
		output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, a);
		if (e && a) begin
			ack_ok = 1'b0;
		end
	endtask
	// pointer then one data byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		byte_io({ADDR, 1'b0}, 1'b1, q);
		byte_io(a, 1'b1, q);
		byte_io(d, 1'b1, q);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		byte_io({ADDR, 1'b0}, 1'b1, q);
		byte_io(a, 1'b1, q);
		start();
		byte_io({ADDR, 1'b1}, 1'b1, q);
		byte_io(8'hFF, 1'b0, d);
		stop();
	endtask
endmodule

// ---- tb/charger_ctrl_test.sv ----
`timescale 1ns/10ps
module charger_ctrl_test;
	logic clk;
	logic srst;
	chg_pkg::sense_t sense_i;
	logic scl;
	logic m_sda;
	logic sda_o;
	logic sda_oe;
	logic sda_w;
	logic al_oe;
	logic al_o;
	chg_pkg::gates_t gates;
	logic fet_on;
	logic pdn_on;
	logic reg_en;
	logic sns_en;
	logic meas_en;
	chg_pkg::dl_level_t dp;
	chg_pkg::dl_level_t dm;
	logic red_req;
	int miscompares;
	int check_count;
	int cyc;
	int n;
	logic [7:0] r;
	logic [7:0] d;
	logic [7:0] q;
	assign sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
	charger_ctrl #(.INT_CYC(20), .PWRUP_CYC(50), .WDT_CYC(2000))
	u_charger_ctrl (
		.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .host_alert_pulse_n_o(al_o),
		.host_alert_pulse_n_oe(al_oe), .sense_i(sense_i),
		.gates(gates), .external_protection_fet_on(fet_on),
		.input_pulldown_on(pdn_on), .internal_regulator_en(reg_en),
		.sense_en(sns_en), .measure_en(meas_en), .dp_level(dp),
		.dm_level(dm), .reduce_current_req(red_req));
	i2c_host u_i2c_host (.scl(scl), .sda_o(m_sda), .sda_i(sda_w));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic int half_cyc(input logic [7:0] f);
		return int'(f) * 4 + 4;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wt(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic sns(input logic [4:0] v);
		@(posedge clk);
		sense_i <= v;
		wt(12);
	endtask
	task automatic wait_g(input logic [7:0] v);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (gates !== v && n < 400);
	endtask
	// alert watched by polling, bounded
	task automatic wait_alert();
		int k;
		k = 0;
		while (al_oe !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
		chk(8'(al_oe), 8'h01);
		chk(8'(al_o), 8'h00);
	endtask
	task automatic wg(input logic [7:0] c, input logic [7:0] g);
		u_i2c_host.wr(chg_pkg::REG_CTRL, c);
		wt(6);
		chk(gates, g);
	endtask
	task automatic do_reset();
		srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		wt(2);
		chk(gates, 8'h00);
		chk(8'(dp), 8'(chg_pkg::DL_HIZ));
		wait_alert();
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			$display("unexpected at %0t: timeout", $time);
			report_and_stop();
		end
	end
	initial begin
		srst = 1'b1;
		sense_i = 5'h1E;
		miscompares = 0;
		check_count = 0;
		cyc = 0;
		r = 8'h5A;
		do_reset();
		u_i2c_host.rd(chg_pkg::REG_PRESET, d);
		chk(d, chg_pkg::PRESET_RST);
		u_i2c_host.rd(8'h40, d);
		chk(d, 8'h00);
		for (int i = 0; i < 7; i++) begin
			r = lfsr(r);
			d = {1'b0, (r[2:0] == 3'h7) ? 3'h6 : r[2:0], 1'b0, 3'(i)};
			u_i2c_host.wr(chg_pkg::REG_PRESET, d);
			chk({1'b0, dm, 1'b0, dp}, d);
			u_i2c_host.rd(chg_pkg::REG_PRESET, q);
			chk(q, d);
		end
		// protections taken as set up, battery above 3V
		wg(8'h08, 8'h00);
		chk(8'(meas_en), 8'h01);
		wg(8'h09, 8'hCC);
		sns(5'h1F);
		chk(8'(red_req), 8'h01);
		sns(5'h1E);
		wg(8'h0A, 8'hCC);
		wg(8'h08, 8'h00);
		u_i2c_host.wr(chg_pkg::REG_CTRL, 8'h0A);
		wait_g(8'hA5);
		wait_g(8'h5A);
		wait_g(8'hA5);
		chk(8'(n), 8'(half_cyc(chg_pkg::SWFREQ_RST)));
		wait_g(8'h5A);
		chk(8'(n), 8'(half_cyc(chg_pkg::SWFREQ_RST)));
		// a shorter period taken while running
		u_i2c_host.wr(chg_pkg::REG_SWFREQ, 8'h0C);
		wait_g(8'h5A);
		wait_g(8'hA5);
		wait_g(8'h5A);
		chk(8'(n), 8'(half_cyc(8'h0C)));
		sns(5'h1C);
		chk(gates, 8'h00);
		wg(8'h09, 8'h00);
		sns(5'h1E);
		wg(8'h10, 8'h00);
		chk(8'({pdn_on, fet_on, reg_en}), 8'h04);
		wg(8'h11, 8'h00);
		wg(8'h00, 8'h00);
		sns(5'h04);
		chk(8'({reg_en, sns_en}), 8'h00);
		sns(5'h1E);
		chk(8'(reg_en), 8'h01);
		u_i2c_host.wr(chg_pkg::REG_CTRL, 8'h0A);
		wt(1000);
		u_i2c_host.rd(chg_pkg::REG_STATUS, q);
		chk(q & 8'h3F, 8'h1A);
		wt(1000);
		chk(8'(meas_en), 8'h01);
		wt(1200);
		chk(8'(meas_en), 8'h00);
		chk(gates, 8'h00);
		do_reset();
		chk(8'(u_i2c_host.ack_ok), 8'h01);
		report_and_stop();
	end
endmodule
